// [src/cstc_pkg.sv]
// constants, layouts and types for the start-bit timing qualifier
package cstc_pkg;
  // register byte offsets
  localparam logic [7:0] ADDR_CTRL   = 8'h00;
  localparam logic [7:0] ADDR_TIMING = 8'h04;
  localparam logic [7:0] ADDR_WAVE   = 8'h08;
  localparam logic [7:0] ADDR_STATUS = 8'h0c;
  localparam logic [7:0] ADDR_CLEAR  = 8'h10;
  localparam logic [7:0] ADDR_IEN    = 8'h14;
  // values after reset and writable masks
  localparam logic [31:0] RST_TIMING  = 32'h0;
  localparam logic [31:0] RST_WAVE    = 32'h0;
  localparam logic [31:0] MASK_TIMING = 32'h00007777;
  localparam logic [31:0] MASK_WAVE   = 32'h00777703;
  // interrupt bit positions
  localparam int IRQ_START = 0;
  localparam int IRQ_WAVE  = 1;
  localparam int IRQ_W     = 2;
  // sampling tick: fs derived from the bus clock
  localparam int CLK_HZ = 40000000;
  localparam int FS_HZ  = 32768;
  localparam int FS_DIV = (CLK_HZ + FS_HZ / 2) / FS_HZ;
  localparam logic [10:0] FS_LAST = 11'(FS_DIV - 1);
  // base times in fs ticks
  localparam logic [7:0] SCYC_MAX_BASE  = 8'h9a;
  localparam logic [7:0] SCYC_MIN_BASE  = 8'h8d;
  localparam logic [7:0] SRISE_MAX_BASE = 8'h80;
  localparam logic [7:0] SRISE_MIN_BASE = 8'h73;
  localparam logic [7:0] ZERO_MAX_BASE  = 8'h38;
  localparam logic [7:0] ZERO_MIN_BASE  = 8'h2b;
  localparam logic [7:0] ONE_MAX_BASE   = 8'h1a;
  localparam logic [7:0] ONE_MIN_BASE   = 8'h0d;
  // a data bit still high more than this many ticks after its falling edge ends the frame
  localparam logic [7:0] BIT_END_TICKS  = 8'h60;
  typedef struct packed {
    logic [16:0] rsv3;
    logic [2:0]  start_cycle_max;
    logic        rsv2;
    logic [2:0]  start_cycle_min;
    logic        rsv1;
    logic [2:0]  start_rise_latest;
    logic        rsv0;
    logic [2:0]  start_rise_earliest;
  } cstc_timing_t;
  typedef struct packed {
    logic [8:0]  rsv3;
    logic [2:0]  zero_rise_latest;
    logic        rsv2;
    logic [2:0]  zero_rise_earliest;
    logic        rsv1;
    logic [2:0]  one_rise_latest;
    logic        rsv0;
    logic [2:0]  one_rise_earliest;
    logic [5:0]  rsv;
    logic        start_detect_irq_enable;
    logic        waveform_check_enable;
  } cstc_wave_t;
  typedef enum logic [2:0] {
    ST_IDLE  = 3'b000,
    ST_SLOW  = 3'b001,
    ST_SHIGH = 3'b011,
    ST_BLOW  = 3'b010,
    ST_BHIGH = 3'b110
  } cstc_state_t;
endpackage

// [src/cstc_rx_timing.sv]
// start-bit and data-bit timing qualifier with apb registers
//
// Behaviour
// - max start cycle is 154 plus field
// - min start cycle is 141 minus field
// - latest start rise is 128 plus field
// - earliest start rise is 115 minus field
// - start rise must fall in rise window
// - start cycle must fall in cycle window
// - zero rise window 43-n to 56+n
// - one rise window 13-n to 26+n
// - waveform check raises waveform error
// - valid start bit raises interrupt
`timescale 1ns/100ps
module cstc_rx_timing #(
  parameter int TICK_DIV = cstc_pkg::FS_DIV // pclk cycles per fs tick
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        cec_in,
  output logic             irq
);
  import cstc_pkg::*;
  // a bench may shorten the tick; the divider must still fit in 11 bits
  localparam logic [10:0] TICK_LAST = 11'(TICK_DIV - 1);

  ////////////////////////////////////////////////////////////////////
  // registers and state
  logic [31:0]      prdata_r;
  logic             pready_r;
  logic             pslverr_r;
  logic             irq_r;
  logic             ren_r;
  cstc_timing_t     tim_r;
  cstc_wave_t       wav_r;
  logic [IRQ_W-1:0] sts_r;
  logic [IRQ_W-1:0] ien_r;
  logic             s1_r;
  logic             s2_r;
  logic             s3_r;
  logic [10:0]      div_r;
  logic [7:0]       cnt_r;
  cstc_state_t      st_r;
  cstc_state_t      st_nxt;

  ////////////////////////////////////////////////////////////////////
  // apb decode
  wire        acc     = psel & penable;
  wire        wr_en   = acc & pwrite & pready_r;
  wire        first   = acc & ~pready_r;
  wire        hit_ctl = (paddr == ADDR_CTRL);
  wire        hit_tim = (paddr == ADDR_TIMING);
  wire        hit_wav = (paddr == ADDR_WAVE);
  wire        hit_sts = (paddr == ADDR_STATUS);
  wire        hit_clr = (paddr == ADDR_CLEAR);
  wire        hit_ien = (paddr == ADDR_IEN);
  wire        hit     = hit_ctl | hit_tim | hit_wav | hit_sts | hit_clr | hit_ien;
  wire        busy    = (st_r != ST_IDLE);
  // control word: bit0 enable, bit1 live busy so software can see the stop
  wire [31:0] ctl_rd  = {30'h0, busy, ren_r};
  wire [31:0] rd_mux  = hit_ctl ? ctl_rd :
                        hit_tim ? 32'(tim_r) :
                        hit_wav ? 32'(wav_r) :
                        hit_sts ? {30'h0, sts_r} :
                        hit_ien ? {30'h0, ien_r} : 32'h0;
  wire [IRQ_W-1:0] clr = (wr_en & hit_clr) ? pwdata[IRQ_W-1:0] : '0;

  // one wait state so read data comes from a flop
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_r  <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r  <= 32'h0;
    end else begin
      pready_r  <= first;
      pslverr_r <= first & ~hit;
      prdata_r  <= (first & ~pwrite) ? rd_mux : 32'h0;
    end
  end

  // config writes land at the completing edge; reserved bits masked off
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ren_r <= 1'b0;
      tim_r <= cstc_timing_t'(RST_TIMING);
      wav_r <= cstc_wave_t'(RST_WAVE);
      ien_r <= '0;
    end else if (wr_en) begin
      if (hit_ctl) ren_r <= pwdata[0];
      if (hit_tim) tim_r <= cstc_timing_t'(pwdata & MASK_TIMING);
      if (hit_wav) wav_r <= cstc_wave_t'(pwdata & MASK_WAVE);
      if (hit_ien) ien_r <= pwdata[IRQ_W-1:0];
    end
  end

  ////////////////////////////////////////////////////////////////////
  // pin synchroniser, edges and fs tick
  wire fall = s3_r & ~s2_r;
  wire rise = ~s3_r & s2_r;
  wire tick = (div_r == TICK_LAST);

  // s1 feeds only s2; line idles high
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s1_r <= 1'b1;
      s2_r <= 1'b1;
      s3_r <= 1'b1;
    end else begin
      s1_r <= cec_in;
      s2_r <= s1_r;
      s3_r <= s2_r;
    end
  end

  // free-running divider; phase error up to one tick is inherent
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) div_r <= 11'h0;
    else          div_r <= tick ? 11'h0 : div_r + 11'h1;
  end

  // ticks since the last falling edge, saturating
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)                    cnt_r <= 8'h0;
    else if (fall)                   cnt_r <= 8'h0;
    else if (tick && cnt_r != 8'hff) cnt_r <= cnt_r + 8'h1;
  end

  ////////////////////////////////////////////////////////////////////
  // window limits
  wire [7:0] scyc_max  = SCYC_MAX_BASE + {5'h0, tim_r.start_cycle_max};
  wire [7:0] scyc_min  = SCYC_MIN_BASE - {5'h0, tim_r.start_cycle_min};
  wire [7:0] srise_max = SRISE_MAX_BASE + {5'h0, tim_r.start_rise_latest};
  wire [7:0] srise_min = SRISE_MIN_BASE - {5'h0, tim_r.start_rise_earliest};
  wire [7:0] zero_max  = ZERO_MAX_BASE + {5'h0, wav_r.zero_rise_latest};
  wire [7:0] zero_min  = ZERO_MIN_BASE - {5'h0, wav_r.zero_rise_earliest};
  wire [7:0] one_max   = ONE_MAX_BASE + {5'h0, wav_r.one_rise_latest};
  wire [7:0] one_min   = ONE_MIN_BASE - {5'h0, wav_r.one_rise_earliest};

  wire srise_ok = (cnt_r >= srise_min) && (cnt_r <= srise_max);
  wire scyc_ok  = (cnt_r >= scyc_min) && (cnt_r <= scyc_max);
  wire zero_ok  = (cnt_r >= zero_min) && (cnt_r <= zero_max);
  wire one_ok   = (cnt_r >= one_min) && (cnt_r <= one_max);
  wire low_long = (cnt_r > zero_max);

  ////////////////////////////////////////////////////////////////////
  // events
  wire start_ok = (st_r == ST_SHIGH) && fall && scyc_ok;
  wire bad_rise = (st_r == ST_BLOW) && rise && !(zero_ok || one_ok);
  wire bad_low  = (st_r == ST_BLOW) && low_long;
  wire ev_start = start_ok && wav_r.start_detect_irq_enable;
  wire ev_wave  = (bad_rise || bad_low) && wav_r.waveform_check_enable;
  wire [IRQ_W-1:0] ev = {ev_wave, ev_start};
  // a new event beats a clear in the same cycle
  wire [IRQ_W-1:0] sts_nxt = (sts_r & ~clr) | ev;

  // frame sequencer; disabling reception drops back to idle at once
  always_comb begin
    st_nxt = st_r;
    unique case (st_r)
      ST_IDLE:  if (fall) st_nxt = ST_SLOW;
      ST_SLOW: begin
        if (rise)                   st_nxt = srise_ok ? ST_SHIGH : ST_IDLE;
        else if (cnt_r > srise_max) st_nxt = ST_IDLE;
      end
      ST_SHIGH: begin
        if (fall)                  st_nxt = scyc_ok ? ST_BLOW : ST_SLOW;
        else if (cnt_r > scyc_max) st_nxt = ST_IDLE;
      end
      ST_BLOW: begin
        if (bad_low)   st_nxt = ST_IDLE;
        else if (rise) st_nxt = ST_BHIGH;
      end
      ST_BHIGH: begin
        if (fall)                       st_nxt = ST_BLOW;
        else if (cnt_r > BIT_END_TICKS) st_nxt = ST_IDLE;
      end
      default: st_nxt = ST_IDLE;
    endcase
    if (!ren_r) st_nxt = ST_IDLE;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) st_r <= ST_IDLE;
    else          st_r <= st_nxt;
  end

  // sticky status and level interrupt
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sts_r <= '0;
      irq_r <= 1'b0;
    end else begin
      sts_r <= sts_nxt;
      irq_r <= |(sts_r & ien_r);
    end
  end

  assign prdata  = prdata_r;
  assign pready  = pready_r;
  assign pslverr = pslverr_r;
  assign irq     = irq_r;

  ////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_start_low;
    (st_r == ST_SLOW) && rise && srise_ok;
  endsequence
  sequence s_start_high;
    (st_r == ST_SHIGH) && fall && scyc_ok;
  endsequence
  sequence s_bit_rise;
    (st_r == ST_BLOW) && rise && !bad_low;
  endsequence
  sequence s_req_first;
    psel && penable && !pready_r;
  endsequence

  a_rise_early_drop: assert property (
    (st_r == ST_SLOW) && rise && (cnt_r < srise_min) |=> st_r == ST_IDLE)
    else $error("early start rise accepted");
  a_rise_window: assert property (
    s_start_low and ren_r |=> st_r == ST_SHIGH)
    else $error("in-window start rise rejected");
  a_rise_late_drop: assert property (
    (st_r == ST_SLOW) && !rise && (cnt_r > srise_max) && ren_r |=> st_r == ST_IDLE)
    else $error("late start rise not dropped");
  a_cycle_accept: assert property (
    s_start_high and ren_r |=> st_r == ST_BLOW)
    else $error("valid start cycle not accepted");
  a_cycle_max: assert property (
    (st_r == ST_SHIGH) && fall && (cnt_r > scyc_max) |=> st_r != ST_BLOW)
    else $error("overlong start cycle accepted");
  a_start_irq_set: assert property (
    s_start_high and wav_r.start_detect_irq_enable |=> sts_r[IRQ_START])
    else $error("start event lost");
  a_start_irq_gate: assert property (
    !$past(wav_r.start_detect_irq_enable) && !$past(sts_r[IRQ_START])
      |-> !sts_r[IRQ_START])
    else $error("start flag set while disabled");
  a_wave_gate: assert property (
    !wav_r.waveform_check_enable && !sts_r[IRQ_WAVE] |=> !sts_r[IRQ_WAVE])
    else $error("waveform flag set while check disabled");
  a_wave_zero_ok: assert property (
    (st_r == ST_BLOW) && rise && zero_ok && !bad_low |=> !$rose(sts_r[IRQ_WAVE]))
    else $error("valid zero bit flagged");
  a_wave_one_bad: assert property (
    (st_r == ST_BLOW) && rise && !one_ok && !zero_ok && wav_r.waveform_check_enable
      |=> sts_r[IRQ_WAVE])
    else $error("bad bit rise not flagged");
  a_rsv_zero: assert property (
    pready_r && !pwrite && hit_tim |-> (prdata_r & ~MASK_TIMING) == 32'h0)
    else $error("reserved timing bits read nonzero");
  a_stop_idle: assert property (
    !ren_r |=> !busy)
    else $error("receiver busy while disabled");
  a_irq_level: assert property (
    (sts_r & ien_r) != '0 |=> irq_r)
    else $error("irq missing for enabled flag");

  // bus side: one wait state, one-cycle answer, error only off the map
  a_pready_wait: assert property (
    s_req_first |=> pready_r)
    else $error("access not answered after one wait");
  a_pready_pulse: assert property (
    pready_r |=> !pready_r)
    else $error("ready held past one cycle");
  a_slverr_map: assert property (
    s_req_first and !hit |=> pslverr_r)
    else $error("unmapped access without error");
  a_slverr_ok: assert property (
    s_req_first and hit |=> !pslverr_r)
    else $error("mapped access flagged as error");
  a_rdata_idle: assert property (
    !pready_r |-> prdata_r == 32'h0)
    else $error("read data outside its cycle");
  a_rsv_wave: assert property (
    pready_r && !pwrite && hit_wav |-> (prdata_r & ~MASK_WAVE) == 32'h0)
    else $error("reserved waveform bits read nonzero");
  a_ctl_write: assert property (
    wr_en && hit_ctl |=> ren_r == $past(pwdata[0]))
    else $error("enable write did not land");
  a_ien_write: assert property (
    wr_en && hit_ien |=> ien_r == $past(pwdata[IRQ_W-1:0]))
    else $error("irq enable write did not land");

  // link side: counter, tick and the drops that end a frame
  a_tick_single: assert property (
    tick |=> !tick)
    else $error("tick wider than one cycle");
  a_cnt_clear: assert property (
    fall |=> cnt_r == 8'h0)
    else $error("count not cleared by falling edge");
  a_cnt_sat: assert property (
    cnt_r == 8'hff && !fall |=> cnt_r == 8'hff)
    else $error("tick count wrapped");
  a_cycle_min: assert property (
    (st_r == ST_SHIGH) && fall && (cnt_r < scyc_min) |=> st_r != ST_BLOW)
    else $error("short start cycle accepted");
  a_cycle_late_drop: assert property (
    (st_r == ST_SHIGH) && !fall && (cnt_r > scyc_max) |=> st_r == ST_IDLE)
    else $error("overlong start cycle not dropped");
  a_low_long_idle: assert property (
    bad_low |=> st_r == ST_IDLE)
    else $error("overlong data low not dropped");
  a_low_long_flag: assert property (
    bad_low && wav_r.waveform_check_enable |=> sts_r[IRQ_WAVE])
    else $error("overlong data low not flagged");
  a_frame_end: assert property (
    (st_r == ST_BHIGH) && !fall && (cnt_r > BIT_END_TICKS) |=> st_r == ST_IDLE)
    else $error("frame not ended by long high");
  a_wave_one_ok: assert property (
    s_bit_rise and one_ok |=> !$rose(sts_r[IRQ_WAVE]))
    else $error("valid one bit flagged");

  // flags come only from the state that owns them; irq follows the enabled set
  a_start_src: assert property (
    $rose(sts_r[IRQ_START]) |-> $past(st_r) == ST_SHIGH)
    else $error("start flag raised outside start high");
  a_wave_src: assert property (
    $rose(sts_r[IRQ_WAVE]) |-> $past(st_r) == ST_BLOW)
    else $error("waveform flag raised outside data low");
  a_irq_drop: assert property (
    (sts_r & ien_r) == '0 |=> !irq_r)
    else $error("irq without enabled flag");

  // every status bit is sticky until cleared, and a set beats a clear
  for (genvar gi = 0; gi < IRQ_W; gi++) begin : g_sticky
    a_sts_hold: assert property (
      sts_r[gi] && !clr[gi] |=> sts_r[gi])
      else $error("status bit lost without clear");
    a_sts_set: assert property (
      ev[gi] |=> sts_r[gi])
      else $error("event did not set status bit");
    a_sts_clear: assert property (
      clr[gi] && !ev[gi] |=> !sts_r[gi])
      else $error("status bit survived clear");
  end
endmodule // cstc_rx_timing

// [verification/cstc_cec_remote.sv]
// remote bus node model that drives the single control wire
`timescale 1ns/100ps
module cstc_cec_remote #(
  parameter int TICK_DIV = cstc_pkg::FS_DIV // pclk cycles per fs tick
) (
  input  wire logic pclk,
  output logic      cec_line
);
  import cstc_pkg::*;
  ////////////////////////////////////////////////////////////////////////////////
  // the wire has a pull-up, so it idles high between frames
  initial cec_line = 1'b1;
  // hold one level for whole fs ticks; the caller lays out the start-bit shape
  task automatic drive(input logic lvl, input int ticks);
    cec_line <= lvl;
    repeat (ticks * TICK_DIV) @(posedge pclk);
  endtask
endmodule // cstc_cec_remote

// [verification/cstc_rx_timing_tb.sv]
// self-checking bench for the start-bit timing qualifier
`timescale 1ns/100ps
module cstc_rx_timing_tb;
  import cstc_pkg::*;
  // short tick keeps frames cheap; every window is counted in ticks anyway
  localparam int TB_DIV = 8;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, cec_in, irq, err;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd;
  int          error_cnt, check_count;
  cstc_rx_timing #(.TICK_DIV(TB_DIV)) i_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .cec_in(cec_in), .irq(irq));
  cstc_cec_remote #(.TICK_DIV(TB_DIV)) i_remote (.pclk(pclk), .cec_line(cec_in));
  ////////////////////////////////////////////////////////////////////////////////
  // 40 MHz bus clock
  initial begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end
  ////////////////////////////////////////////////////////////////////////////////
  // verdict and end of run
  task automatic summarize();
    $display("checks %0d mismatches %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("wrong value %s expected %h seen %h", name, exp, got);
    end
  endtask
  // one apb transfer; waits for pready under a bound, no latency assumed
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d; penable <= 1'b0;
    @(posedge pclk);
    penable <= 1'b1;
    for (n = 0; n < 20; n++) begin
      @(posedge pclk);
      if (pready === 1'b1) break;
    end
    if (n == 20) begin
      error_cnt++;
      summarize();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0; penable <= 1'b0;
    @(posedge pclk);
  endtask
  // stop, confirm the receiver is idle, retime, restart
  task automatic retime(input logic [31:0] t);
    apb(1'b1, ADDR_CTRL, 32'h0);
    apb(1'b0, ADDR_CTRL, 32'h0); check("stopped", 32'h0, rd);
    apb(1'b1, ADDR_TIMING, t);
    apb(1'b1, ADDR_CTRL, 32'h1);
  endtask
  // start bit, one data bit low for dl ticks, then high long enough to end the frame
  task automatic frame(input int lo, input int hi, input int dl, input logic [31:0] exp);
    i_remote.drive(1'b0, lo);
    i_remote.drive(1'b1, hi);
    i_remote.drive(1'b0, dl);
    i_remote.drive(1'b1, 100);
    apb(1'b0, ADDR_STATUS, 32'h0); check("frame status", exp, rd);
    apb(1'b1, ADDR_CLEAR, 32'h3);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
    paddr = 8'h00; pwdata = 32'h0; error_cnt = 0; check_count = 0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(1'b0, ADDR_TIMING, 32'h0); check("timing reset", RST_TIMING, rd);
    apb(1'b0, ADDR_WAVE, 32'h0); check("wave reset", RST_WAVE, rd);
    // reserved bits must drop every written one
    apb(1'b1, ADDR_TIMING, 32'hffffffff);
    apb(1'b0, ADDR_TIMING, 32'h0); check("timing mask", MASK_TIMING, rd);
    apb(1'b1, ADDR_WAVE, 32'hffffffff);
    apb(1'b0, ADDR_WAVE, 32'h0); check("wave mask", MASK_WAVE, rd);
    apb(1'b0, 8'h18, 32'h0); check("unmapped err", 32'h1, {31'h0, err});
    check("unmapped data", 32'h0, rd);
    // stop reception and confirm before retiming to base values
    apb(1'b1, ADDR_CTRL, 32'h0);
    apb(1'b0, ADDR_CTRL, 32'h0); check("enable off", 32'h0, rd);
    apb(1'b1, ADDR_TIMING, 32'h0);
    apb(1'b1, ADDR_WAVE, 32'h3);
    apb(1'b1, ADDR_IEN, 32'h3);
    apb(1'b1, ADDR_CTRL, 32'h1);
    // start bit: rise at tick 122, next fall at tick 148
    i_remote.drive(1'b0, 122);
    i_remote.drive(1'b1, 26);
    i_remote.drive(1'b0, 10);
    apb(1'b0, ADDR_STATUS, 32'h0); check("start flag", 32'h1, rd);
    check("irq start", 32'h1, {31'h0, irq});
    // data bit rising near tick 35 sits between both windows
    i_remote.drive(1'b0, 25);
    i_remote.drive(1'b1, 4);
    apb(1'b0, ADDR_STATUS, 32'h0); check("wave error", 32'h3, rd);
    apb(1'b1, ADDR_CLEAR, 32'h1);
    apb(1'b0, ADDR_STATUS, 32'h0); check("clear start", 32'h2, rd);
    // mask the remaining error, then unmask it
    apb(1'b1, ADDR_IEN, 32'h1);
    repeat (2) @(posedge pclk);
    check("irq masked", 32'h0, {31'h0, irq});
    apb(1'b1, ADDR_IEN, 32'h3);
    repeat (2) @(posedge pclk);
    check("irq unmasked", 32'h1, {31'h0, irq});
    apb(1'b1, ADDR_CLEAR, 32'h3);
    apb(1'b0, ADDR_STATUS, 32'h0); check("clear all", 32'h0, rd);
    check("irq cleared", 32'h0, {31'h0, irq});
    apb(1'b0, ADDR_CLEAR, 32'h0); check("clear reads", 32'h0, rd);
    // base windows refuse early rise, late rise, long and short cycles
    retime(32'h0);
    frame(112, 36, 20, 32'h0);
    frame(131, 17, 20, 32'h0);
    frame(122, 35, 20, 32'h0);
    frame(122, 16, 20, 32'h0);
    // widest windows take the same shapes; one frame carries a valid zero bit
    retime(MASK_TIMING);
    frame(112, 36, 20, 32'h1);
    frame(131, 17, 20, 32'h1);
    frame(122, 35, 48, 32'h1);
    frame(122, 16, 20, 32'h1);
    summarize();
  end
endmodule // cstc_rx_timing_tb
